//--- core/wef_core.sv
// Event capture, wake-up, fail-safe and mode logic of the CAN transceiver
module wef_core #(
  parameter int unsigned TDOM_NS = wef_pkg::TDOM_NS_DEF,
  parameter int unsigned EVT_DLY_NS = wef_pkg::EVT_DLY_NS_DEF,
  parameter int unsigned SILENCE_NS = wef_pkg::SILENCE_NS_DEF
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Serial register port
  input wire logic SCK,
  input wire logic SCSN_N,
  input wire logic SDI,
  output logic SDO,
  // CAN side
  input wire logic TRANSMIT_DATA_IN,
  input wire logic BUS_RX,
  input wire logic BUS_ACTIVITY,
  input wire logic CAN_WAKE_DET,
  output logic RECEIVE_DATA_OUT,
  output logic CAN_TX_DRIVE,
  // Supervisory inputs
  input wire logic WAKE_IN,
  input wire logic VCC_UV,
  input wire logic OVERTEMP,
  input wire logic PN_FRAME_ERR,
  // Supply control
  output logic SUPPLY_ENABLE_OUT
);
  import wef_pkg::*;

  localparam int unsigned DOM_CYC = (TDOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EVT_DLY_CYC = (EVT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SILENCE_CYC = (SILENCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Write decode: {hit, byte} for one address of the last serial write
  function automatic logic [8:0] wbyte(input wef_wr_t w, input logic [6:0] a);
    logic [6:0] d;
    d = 7'(a - w.addr);
    wbyte = 9'h000;
    if (w.valid && d < {5'h00, w.nbytes}) begin
      case (d)
        7'h00: wbyte = {1'b1, w.data[23:16]};
        7'h01: wbyte = {1'b1, w.data[15:8]};
        default: wbyte = {1'b1, w.data[7:0]};
      endcase
    end
  endfunction

  // State
  wef_mode_t mode_reg, mode_next;
  wef_ev_t status_reg, status_next;
  logic [1:0] cmc_reg;
  logic otwe_reg, spife_reg, bus_silence_enable_reg, cfe_reg, cwe_reg, wake_rise_enable_reg, wake_fall_enable_reg;
  logic tx_dis_reg;
  logic [31:0] dom_cnt_reg;
  logic [31:0] sil_cnt_reg;
  logic [31:0] dly_cnt_reg;
  logic dly_run_reg;
  logic was_active_reg;
  logic wake_prev_reg, uv_prev_reg, otw_prev_reg;
  logic rxd_reg, tx_drive_reg, inh_reg;

  // Serial port
  wef_wr_t spi_wr;
  logic spi_len_err;
  logic [6:0] spi_rd_addr;
  logic [7:0] rd_data;

  wef_spi u_spi (
    .clk(CLK),
    .rst(SYS_RST),
    .sck(SCK),
    .scsn_n(SCSN_N),
    .sdi(SDI),
    .sdo(SDO),
    .rd_data(rd_data),
    .rd_addr(spi_rd_addr),
    .wr(spi_wr),
    .len_err(spi_len_err)
  );

  // Write decode
  wire [8:0] w_mode = wbyte(spi_wr, ADDR_MODE);
  wire [8:0] w_sys_en = wbyte(spi_wr, ADDR_SYS_EN);
  wire [8:0] w_can = wbyte(spi_wr, ADDR_CAN_CTRL);
  wire [8:0] w_trx_en = wbyte(spi_wr, ADDR_TRX_EN);
  wire [8:0] w_wake_en = wbyte(spi_wr, ADDR_WAKE_EN);
  wire [8:0] w_sys_evt = wbyte(spi_wr, ADDR_SYS_EVT);
  wire [8:0] w_trx_evt = wbyte(spi_wr, ADDR_TRX_EVT);
  wire [8:0] w_wake_evt = wbyte(spi_wr, ADDR_WAKE_EVT);
  wire [8:0] w_lvl = wbyte(spi_wr, ADDR_WAKE_LVL);
  wire [8:0] w_glb = wbyte(spi_wr, ADDR_GLOBAL);
  wire [8:0] w_tst = wbyte(spi_wr, ADDR_TRX_STAT);
  wire locked_wr = w_lvl[8] | w_glb[8] | w_tst[8];
  wire [2:0] mc_code = w_mode[2:0];
  wire mc_legal = (mc_code == MC_SLEEP) | (mc_code == MC_STANDBY) | (mc_code == MC_NORMAL);
  wire bad_mode = w_mode[8] & ~mc_legal;

  // Mode decode
  wire is_normal = (mode_reg == WEF_NORMAL);
  wire is_sleep = (mode_reg == WEF_SLEEP);
  wire can_active = is_normal & ((cmc_reg == CMC_ACTIVE_UV) | (cmc_reg == CMC_ACTIVE));
  wire can_offline = ~is_normal | (cmc_reg == CMC_OFFLINE);

  // Dominant time-out
  wire txd_low = can_active & ~TRANSMIT_DATA_IN;
  wire dom_expire = txd_low & ~tx_dis_reg & (dom_cnt_reg == 32'(DOM_CYC - 1));
  wire cts = can_active & ~tx_dis_reg;

  // Raw event sources
  wire uv_rise = VCC_UV & ~uv_prev_reg;
  wire uv_fail = uv_rise & can_active & (cmc_reg == CMC_ACTIVE_UV);
  wire sil_expire = was_active_reg & (sil_cnt_reg == 32'(SILENCE_CYC - 1));
  wire wake_rise = WAKE_IN & ~wake_prev_reg;
  wire wake_fall = ~WAKE_IN & wake_prev_reg;

  // Captured events
  wef_ev_t set_ev, clr_ev;
  assign set_ev.po = 1'b0;
  assign set_ev.overheat_warning_flag = OVERTEMP & ~otw_prev_reg & is_normal & otwe_reg;
  assign set_ev.spi_failure_flag = (spi_len_err | bad_mode | locked_wr) & spife_reg;
  assign set_ev.pn_frame_error_flag = PN_FRAME_ERR;
  assign set_ev.bus_silence_flag = sil_expire & bus_silence_enable_reg;
  assign set_ev.cf = (dom_expire | uv_fail) & cfe_reg & ~is_sleep;
  assign set_ev.cw = CAN_WAKE_DET & can_offline & cwe_reg;
  assign set_ev.wake_rise_flag = wake_rise & wake_rise_enable_reg;
  assign set_ev.wake_fall_flag = wake_fall & wake_fall_enable_reg;

  // Write-one-to-clear
  assign clr_ev.po = w_sys_evt[B_PO];
  assign clr_ev.overheat_warning_flag = w_sys_evt[B_OTW];
  assign clr_ev.spi_failure_flag = w_sys_evt[B_SPI_FAILURE_FLAG];
  assign clr_ev.pn_frame_error_flag = w_trx_evt[B_PN_FRAME_ERROR_FLAG];
  assign clr_ev.bus_silence_flag = w_trx_evt[B_CBS];
  assign clr_ev.cf = w_trx_evt[B_CF];
  assign clr_ev.cw = w_trx_evt[B_CW];
  assign clr_ev.wake_rise_flag = w_wake_evt[B_WPR];
  assign clr_ev.wake_fall_flag = w_wake_evt[B_WPF];

  // Set wins over clear
  assign status_next = (status_reg & ~clr_ev) | set_ev;
  wire cleared_any = |(status_reg & clr_ev);
  wire pending = |status_reg;
  wire regular_en = cwe_reg | wake_rise_enable_reg | wake_fall_enable_reg;
  wire sleep_wake = |{set_ev.po, set_ev.overheat_warning_flag, set_ev.pn_frame_error_flag, set_ev.bus_silence_flag, set_ev.cf, set_ev.cw,
                      set_ev.wake_rise_flag, set_ev.wake_fall_flag};

  // Global summary
  wire syse = status_reg.po | status_reg.overheat_warning_flag | status_reg.spi_failure_flag;
  wire trxe = status_reg.pn_frame_error_flag | status_reg.bus_silence_flag | status_reg.cf | status_reg.cw;
  wire wpe = status_reg.wake_rise_flag | status_reg.wake_fall_flag;
  wire wake_level_status = WAKE_IN & (is_normal | wake_rise_enable_reg | wake_fall_enable_reg);

  // Mode transitions
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      WEF_SLEEP: begin
        if (sleep_wake) begin
          mode_next = WEF_STANDBY;
        end else if (w_mode[8] && mc_code == MC_STANDBY) begin
          mode_next = WEF_STANDBY;
        end else if (w_mode[8] && mc_code == MC_NORMAL) begin
          mode_next = WEF_NORMAL;
        end
      end
      WEF_STANDBY, WEF_NORMAL: begin
        if (w_mode[8] && mc_code == MC_SLEEP) begin
          mode_next = (regular_en && !pending) ? WEF_SLEEP : WEF_STANDBY;
        end else if (w_mode[8] && mc_code == MC_STANDBY) begin
          mode_next = WEF_STANDBY;
        end else if (w_mode[8] && mc_code == MC_NORMAL) begin
          mode_next = WEF_NORMAL;
        end
      end
      default: mode_next = WEF_STANDBY;
    endcase
  end

  // Register read
  always_comb begin
    rd_data = 8'h00;
    case (spi_rd_addr)
      ADDR_MODE: rd_data = (mode_reg == WEF_SLEEP) ? {5'h00, MC_SLEEP} :
                           (mode_reg == WEF_NORMAL) ? {5'h00, MC_NORMAL} : {5'h00, MC_STANDBY};
      ADDR_SYS_EN: rd_data = 8'({otwe_reg, spife_reg, 1'b0});
      ADDR_CAN_CTRL: rd_data = {6'h00, cmc_reg};
      ADDR_TRX_STAT: rd_data = {cts, 5'h00, VCC_UV, tx_dis_reg};
      ADDR_TRX_EN: rd_data = {3'h0, bus_silence_enable_reg, 2'h0, cfe_reg, cwe_reg};
      ADDR_WAKE_LVL: rd_data = {6'h00, wake_level_status, 1'b0};
      ADDR_WAKE_EN: rd_data = {6'h00, wake_rise_enable_reg, wake_fall_enable_reg};
      ADDR_GLOBAL: rd_data = {4'h0, wpe, trxe, 1'b0, syse};
      ADDR_SYS_EVT: rd_data = {3'h0, status_reg.po, 1'b0, status_reg.overheat_warning_flag, status_reg.spi_failure_flag, 1'b0};
      ADDR_TRX_EVT: rd_data = {2'h0, status_reg.pn_frame_error_flag, status_reg.bus_silence_flag, 2'h0,
                               status_reg.cf, status_reg.cw};
      ADDR_WAKE_EVT: rd_data = {6'h00, status_reg.wake_rise_flag, status_reg.wake_fall_flag};
      default: rd_data = 8'h00;
    endcase
  end

  // Control and status flops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mode_reg <= WEF_STANDBY;
      status_reg <= EV_RESET;
      cmc_reg <= CMC_OFFLINE;
      otwe_reg <= 1'b0;
      spife_reg <= 1'b0;
      bus_silence_enable_reg <= 1'b0;
      cfe_reg <= 1'b0;
      cwe_reg <= 1'b0;
      wake_rise_enable_reg <= 1'b0;
      wake_fall_enable_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      status_reg <= status_next;
      if (w_can[8]) begin
        cmc_reg <= w_can[1:0];
      end
      if (w_sys_en[8]) begin
        otwe_reg <= w_sys_en[B_OTWE];
        spife_reg <= w_sys_en[B_SPIFE];
      end
      if (w_trx_en[8]) begin
        bus_silence_enable_reg <= w_trx_en[B_BUS_SILENCE_ENABLE];
        cfe_reg <= w_trx_en[B_CFE];
        cwe_reg <= w_trx_en[B_CWE];
      end
      if (w_wake_en[8]) begin
        wake_rise_enable_reg <= w_wake_en[B_WAKE_RISE_ENABLE];
        wake_fall_enable_reg <= w_wake_en[B_WAKE_FALL_ENABLE];
      end
    end
  end

  // Dominant time-out counter and transmitter disable
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dom_cnt_reg <= 32'h0;
      tx_dis_reg <= 1'b0;
    end else begin
      if (!txd_low || tx_dis_reg) begin
        dom_cnt_reg <= 32'h0;
      end else begin
        dom_cnt_reg <= 32'(dom_cnt_reg + 32'h1);
      end
      if (!can_active || TRANSMIT_DATA_IN) begin
        tx_dis_reg <= 1'b0;
      end else if (dom_expire) begin
        tx_dis_reg <= 1'b1;
      end
    end
  end

  // Bus silence watch
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sil_cnt_reg <= 32'h0;
      was_active_reg <= 1'b0;
    end else begin
      if (BUS_ACTIVITY || sil_expire) begin
        sil_cnt_reg <= 32'h0;
      end else if (was_active_reg) begin
        sil_cnt_reg <= 32'(sil_cnt_reg + 32'h1);
      end
      if (BUS_ACTIVITY) begin
        was_active_reg <= 1'b1;
      end else if (sil_expire) begin
        was_active_reg <= 1'b0;
      end
    end
  end

  // Event delay after a clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dly_cnt_reg <= 32'h0;
      dly_run_reg <= 1'b0;
    end else if (cleared_any) begin
      dly_cnt_reg <= 32'h0;
      dly_run_reg <= 1'b1;
    end else if (dly_run_reg && dly_cnt_reg == 32'(EVT_DLY_CYC - 1)) begin
      dly_run_reg <= 1'b0;
    end else if (dly_run_reg) begin
      dly_cnt_reg <= 32'(dly_cnt_reg + 32'h1);
    end
  end

  // Edge history and pin outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wake_prev_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
      otw_prev_reg <= 1'b0;
      rxd_reg <= 1'b1;
      tx_drive_reg <= 1'b0;
      inh_reg <= 1'b1;
    end else begin
      wake_prev_reg <= WAKE_IN;
      uv_prev_reg <= VCC_UV;
      otw_prev_reg <= OVERTEMP;
      if (can_offline) begin
        rxd_reg <= ~(pending & ~dly_run_reg & ~cleared_any);
      end else begin
        rxd_reg <= BUS_RX;
      end
      tx_drive_reg <= txd_low & ~tx_dis_reg & ~dom_expire;
      inh_reg <= (mode_next != WEF_SLEEP);
    end
  end

  assign RECEIVE_DATA_OUT = rxd_reg;
  assign CAN_TX_DRIVE = tx_drive_reg;
  assign SUPPLY_ENABLE_OUT = inh_reg;

endmodule

//--- core/wef_pkg.sv
// Package: register map, field positions, codes and types of the wake/event block
package wef_pkg;

  // Clock period
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Default times in ns
  localparam int unsigned TDOM_NS_DEF = 2000000;
  localparam int unsigned EVT_DLY_NS_DEF = 400000;
  localparam int unsigned SILENCE_NS_DEF = 1000000000;

  // Register addresses
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_SYS_EN = 7'h04;
  localparam logic [6:0] ADDR_CAN_CTRL = 7'h20;
  localparam logic [6:0] ADDR_TRX_STAT = 7'h22;
  localparam logic [6:0] ADDR_TRX_EN = 7'h23;
  localparam logic [6:0] ADDR_WAKE_LVL = 7'h4b;
  localparam logic [6:0] ADDR_WAKE_EN = 7'h4c;
  localparam logic [6:0] ADDR_GLOBAL = 7'h60;
  localparam logic [6:0] ADDR_SYS_EVT = 7'h61;
  localparam logic [6:0] ADDR_TRX_EVT = 7'h63;
  localparam logic [6:0] ADDR_WAKE_EVT = 7'h64;

  // Field positions
  localparam int B_PO = 4;
  localparam int B_OTW = 2;
  localparam int B_SPI_FAILURE_FLAG = 1;
  localparam int B_PN_FRAME_ERROR_FLAG = 5;
  localparam int B_CBS = 4;
  localparam int B_CF = 1;
  localparam int B_CW = 0;
  localparam int B_WPR = 1;
  localparam int B_WPF = 0;
  localparam int B_WAKE_LEVEL_STATUS = 1;
  localparam int B_CTS = 7;
  localparam int B_VCS = 1;
  localparam int B_CFS = 0;
  localparam int B_GWPE = 3;
  localparam int B_GTRXE = 2;
  localparam int B_GSYSE = 0;
  localparam int B_OTWE = 2;
  localparam int B_SPIFE = 1;
  localparam int B_BUS_SILENCE_ENABLE = 4;
  localparam int B_CFE = 1;
  localparam int B_CWE = 0;
  localparam int B_WAKE_RISE_ENABLE = 1;
  localparam int B_WAKE_FALL_ENABLE = 0;

  // Operating mode command codes
  localparam logic [2:0] MC_SLEEP = 3'h1;
  localparam logic [2:0] MC_STANDBY = 3'h4;
  localparam logic [2:0] MC_NORMAL = 3'h7;

  // CAN mode select codes
  localparam logic [1:0] CMC_OFFLINE = 2'h0;
  localparam logic [1:0] CMC_ACTIVE_UV = 2'h1;
  localparam logic [1:0] CMC_ACTIVE = 2'h2;
  localparam logic [1:0] CMC_LISTEN = 2'h3;

  // Serial frame lengths and bit-count saturation value
  localparam logic [5:0] SPI_LEN16 = 6'h10;
  localparam logic [5:0] SPI_LEN24 = 6'h18;
  localparam logic [5:0] SPI_LEN32 = 6'h20;
  localparam logic [5:0] SPI_CNT_SAT = 6'h21;

  // Operating modes
  typedef enum logic [1:0] {
    WEF_STANDBY = 2'b00,
    WEF_NORMAL = 2'b01,
    WEF_SLEEP = 2'b10
  } wef_mode_t;

  // Event flags
  typedef struct packed {
    logic po;
    logic overheat_warning_flag;
    logic spi_failure_flag;
    logic pn_frame_error_flag;
    logic bus_silence_flag;
    logic cf;
    logic cw;
    logic wake_rise_flag;
    logic wake_fall_flag;
  } wef_ev_t;

  localparam logic [8:0] EV_RESET = 9'h100;

  // Completed serial write
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [1:0] nbytes;
    logic [23:0] data;
  } wef_wr_t;

endpackage

//--- core/wef_spi.sv
// Serial register port: frame length check, write bundle, read shift-out
module wef_spi (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck,
  input wire logic scsn_n,
  input wire logic sdi,
  output logic sdo,
  // Register side
  input wire logic [7:0] rd_data,
  output logic [6:0] rd_addr,
  output wef_pkg::wef_wr_t wr,
  output logic len_err
);
  import wef_pkg::*;

  logic sck_prev_reg;
  logic cs_prev_reg;
  logic [5:0] cnt_reg;
  logic [31:0] sh_reg;
  logic [7:0] addr_reg;
  logic [7:0] out_reg;
  logic sdo_reg;
  wef_wr_t wr_reg;
  logic len_err_reg;

  wire sck_rise = ~scsn_n & sck & ~sck_prev_reg;
  wire sck_fall = ~scsn_n & ~sck & sck_prev_reg;
  wire cs_start = ~scsn_n & cs_prev_reg;
  wire cs_end = scsn_n & ~cs_prev_reg;
  wire len_ok = (cnt_reg == SPI_LEN16) | (cnt_reg == SPI_LEN24) | (cnt_reg == SPI_LEN32);
  wire byte_edge = (cnt_reg[2:0] == 3'h0) & (cnt_reg != 6'h00);
  wire [1:0] nbytes = 2'(cnt_reg[5:3] - 3'h1);
  wire [23:0] wdata = (cnt_reg == SPI_LEN16) ? {sh_reg[7:0], 16'h0000} :
                      (cnt_reg == SPI_LEN24) ? {sh_reg[15:0], 8'h00} : sh_reg[23:0];

  assign rd_addr = 7'(addr_reg[7:1] + {4'h0, cnt_reg[5:3]} - 7'h01);
  assign sdo = sdo_reg;
  assign wr = wr_reg;
  assign len_err = len_err_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      cnt_reg <= 6'h00;
      sh_reg <= 32'h0;
      addr_reg <= 8'h00;
      out_reg <= 8'h00;
      sdo_reg <= 1'b0;
      wr_reg <= '0;
      len_err_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck;
      cs_prev_reg <= scsn_n;
      if (cs_start) begin
        cnt_reg <= 6'h00;
      end else if (sck_rise && cnt_reg != SPI_CNT_SAT) begin
        cnt_reg <= 6'(cnt_reg + 6'h01);
      end
      if (sck_rise) begin
        sh_reg <= {sh_reg[30:0], sdi};
      end
      if (sck_rise && cnt_reg == 6'h07) begin
        addr_reg <= {sh_reg[6:0], sdi};
      end
      // Data bytes shift out MSB first after the address byte
      if (cs_start) begin
        sdo_reg <= 1'b0;
      end else if (sck_fall && byte_edge) begin
        sdo_reg <= rd_data[7];
        out_reg <= {rd_data[6:0], 1'b0};
      end else if (sck_fall) begin
        sdo_reg <= out_reg[7];
        out_reg <= {out_reg[6:0], 1'b0};
      end
      wr_reg.valid <= cs_end & len_ok & ~addr_reg[0];
      wr_reg.addr <= addr_reg[7:1];
      wr_reg.nbytes <= nbytes;
      wr_reg.data <= wdata;
      len_err_reg <= cs_end & ~len_ok;
    end
  end

endmodule

//--- dv/test_wef_core.sv
// Testbench of the wake/event block
module test_wef_core;
  timeunit 1ns;
  timeprecision 1ps;
  import wef_pkg::*;
  logic clk = 1'b0;
  logic rst, txd, wake, uv, overheat_warning_flag, pnfe, sck, scsn_n, sdi, sdo, rxd, txdrv, supply_enable_output;
  logic bus_rx, act, cwake;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  wef_core #(.TDOM_NS(40), .EVT_DLY_NS(40), .SILENCE_NS(80)) dut (.CLK(clk), .SYS_RST(rst),
    .SCK(sck), .SCSN_N(scsn_n), .SDI(sdi), .SDO(sdo), .TRANSMIT_DATA_IN(txd), .BUS_RX(bus_rx),
    .BUS_ACTIVITY(act), .CAN_WAKE_DET(cwake), .RECEIVE_DATA_OUT(rxd), .CAN_TX_DRIVE(txdrv),
    .WAKE_IN(wake), .VCC_UV(uv), .OVERTEMP(overheat_warning_flag), .PN_FRAME_ERR(pnfe),
    .SUPPLY_ENABLE_OUT(supply_enable_output));
  wef_host u_host (.clk(clk), .sck(sck), .scsn_n(scsn_n), .sdi(sdi), .sdo(sdo));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer({a, 1'b0, d}, 16, q);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    u_host.xfer({a, 1'b1, 8'h00}, 16, q);
    chk(q & m, e);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic t_power;
    chk({7'h0, rxd}, 8'h00);
    rdchk(ADDR_SYS_EVT, 8'hff, 8'h10);
    rdchk(ADDR_GLOBAL, 8'h0d, 8'h01);
    rdchk(ADDR_WAKE_EN, 8'h03, 8'h00);
    wr(ADDR_SYS_EVT, 8'h00);
    rdchk(ADDR_SYS_EVT, 8'hff, 8'h10);
    wr(ADDR_SYS_EVT, 8'h10);
    chk({7'h0, rxd}, 8'h01);
    tick(14);
    chk({7'h0, rxd}, 8'h01);
    rdchk(ADDR_GLOBAL, 8'h0d, 8'h00);
  endtask
  task automatic t_fail;
    wr(ADDR_TRX_EN, 8'h02);
    wr(ADDR_CAN_CTRL, 8'h02);
    wr(ADDR_MODE, {5'h0, MC_NORMAL});
    chk({7'h0, rxd}, 8'h00);
    bus_rx <= 1'b1;
    tick(2);
    chk({7'h0, rxd}, 8'h01);
    bus_rx <= 1'b0;
    txd <= 1'b0;
    tick(6);
    txd <= 1'b1;
    tick(1);
    txd <= 1'b0;
    tick(6);
    chk({7'h0, txdrv}, 8'h01);
    tick(8);
    chk({7'h0, txdrv}, 8'h00);
    rdchk(ADDR_TRX_STAT, 8'h81, 8'h01);
    rdchk(ADDR_TRX_EVT, 8'h02, 8'h02);
    txd <= 1'b1;
    wr(ADDR_TRX_EVT, 8'h02);
    wr(ADDR_CAN_CTRL, 8'h01);
    uv <= 1'b1;
    tick(4);
    rdchk(ADDR_TRX_STAT, 8'h02, 8'h02);
    uv <= 1'b0;
    rdchk(ADDR_TRX_EVT, 8'h02, 8'h02);
    wr(ADDR_TRX_EVT, 8'h02);
    wr(ADDR_SYS_EN, 8'h06);
    overheat_warning_flag <= 1'b1;
    tick(2);
    overheat_warning_flag <= 1'b0;
    rdchk(ADDR_SYS_EVT, 8'h04, 8'h04);
    wr(ADDR_SYS_EVT, 8'h04);
  endtask
  task automatic t_wake;
    wr(ADDR_MODE, {5'h0, MC_STANDBY});
    wr(ADDR_CAN_CTRL, 8'h00);
    overheat_warning_flag <= 1'b1;
    tick(2);
    overheat_warning_flag <= 1'b0;
    rdchk(ADDR_SYS_EVT, 8'h04, 8'h00);
    wr(ADDR_WAKE_EN, 8'h02);
    wake <= 1'b1;
    tick(4);
    rdchk(ADDR_WAKE_LVL, 8'h02, 8'h02);
    rdchk(ADDR_WAKE_EVT, 8'h03, 8'h02);
    chk({7'h0, rxd}, 8'h00);
    wake <= 1'b0;
    tick(4);
    rdchk(ADDR_WAKE_EVT, 8'h03, 8'h02);
    wr(ADDR_WAKE_EN, 8'h03);
    wake <= 1'b1;
    tick(4);
    wake <= 1'b0;
    tick(4);
    rdchk(ADDR_WAKE_EVT, 8'h03, 8'h03);
    wr(ADDR_WAKE_EVT, 8'h01);
    chk({7'h0, rxd}, 8'h01);
    tick(14);
    chk({7'h0, rxd}, 8'h00);
    rdchk(ADDR_WAKE_EVT, 8'h03, 8'h02);
    wr(ADDR_WAKE_EVT, 8'h02);
  endtask
  task automatic t_bus;
    wr(ADDR_TRX_EN, 8'h13);
    act <= 1'b1;
    cwake <= 1'b1;
    tick(1);
    act <= 1'b0;
    cwake <= 1'b0;
    tick(25);
    rdchk(ADDR_TRX_EVT, 8'h01, 8'h01);
    rdchk(ADDR_TRX_EVT, 8'h10, 8'h10);
    wr(ADDR_TRX_EVT, 8'h11);
    rdchk(ADDR_TRX_EVT, 8'h11, 8'h00);
  endtask
  task automatic t_spi_failure_flag;
    logic [7:0] q;
    wr(ADDR_SYS_EN, 8'h02);
    for (int k = 0; k < 3; k++) begin
      if (k == 0) u_host.xfer({ADDR_TRX_EN, 1'b0, 8'h02}, 15, q);
      else if (k == 1) wr(ADDR_MODE, 8'h02);
      else wr(ADDR_GLOBAL, 8'h01);
      rdchk(ADDR_SYS_EVT, 8'h02, 8'h02);
      wr(ADDR_SYS_EVT, 8'h02);
    end
  endtask
  task automatic t_sleep;
    wr(ADDR_CAN_CTRL, 8'h02);
    pnfe <= 1'b1;
    tick(1);
    pnfe <= 1'b0;
    wr(ADDR_MODE, {5'h0, MC_SLEEP});
    chk({7'h0, supply_enable_output}, 8'h01);
    rdchk(ADDR_MODE, 8'h07, {5'h0, MC_STANDBY});
    rdchk(ADDR_TRX_EVT, 8'h20, 8'h20);
    wr(ADDR_TRX_EVT, 8'h20);
    tick(14);
    wr(ADDR_MODE, {5'h0, MC_SLEEP});
    chk({7'h0, supply_enable_output}, 8'h00);
    wr(ADDR_GLOBAL, 8'h01);
    chk({7'h0, supply_enable_output}, 8'h00);
    txd <= 1'b0;
    tick(16);
    txd <= 1'b1;
    pnfe <= 1'b1;
    tick(1);
    pnfe <= 1'b0;
    tick(3);
    chk({7'h0, supply_enable_output}, 8'h01);
    rdchk(ADDR_TRX_EVT, 8'h22, 8'h20);
    rdchk(ADDR_SYS_EVT, 8'h02, 8'h02);
  endtask
  initial begin
    rst = 1'b1;
    txd = 1'b1;
    wake = 1'b0;
    uv = 1'b0;
    overheat_warning_flag = 1'b0;
    pnfe = 1'b0;
    bus_rx = 1'b0;
    act = 1'b0;
    cwake = 1'b0;
    tick(8);
    rst <= 1'b0;
    tick(4);
    t_power();
    t_fail();
    t_wake();
    t_bus();
    t_spi_failure_flag();
    t_sleep();
    conclude();
  end
endmodule

//--- dv/wef_host.sv
// Host serial master model, mode 0, MSB first
module wef_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sck,
  output logic scsn_n,
  output logic sdi,
  input wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    scsn_n = 1'b1;
    sdi = 1'b0;
  end
  // Clock stands low outside frames; data toggles when deselected
  task automatic xfer(input logic [15:0] w, input int nb, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk);
    scsn_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      sdi <= w[15 - i];
      repeat (2) @(posedge clk);
      sck <= 1'b1;
      q = {q[6:0], sdo};
      repeat (3) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (3) @(posedge clk);
    scsn_n <= 1'b1;
    sdi <= ~sdi;
    repeat (5) @(posedge clk);
  endtask
endmodule

//--- dv/wef_props.sv
// Port checker of the wake/event block
module wef_props #(
  parameter int unsigned TDOM_NS = 40
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // Watched pins
  input wire logic SCSN_N,
  input wire logic TRANSMIT_DATA_IN,
  input wire logic BUS_RX,
  input wire logic PN_FRAME_ERR,
  input wire logic RECEIVE_DATA_OUT,
  input wire logic CAN_TX_DRIVE,
  input wire logic SUPPLY_ENABLE_OUT
);
  localparam int DOM_CYC = (TDOM_NS + wef_pkg::CLK_PERIOD_NS - 1) / wef_pkg::CLK_PERIOD_NS;
  logic [7:0] lo_cnt_reg;
  logic [7:0] lo_cnt_next;
  assign lo_cnt_next = (lo_cnt_reg == 8'hff) ? lo_cnt_reg : lo_cnt_reg + 8'h01;
  always_ff @(posedge CLK) begin
    lo_cnt_reg <= (SYS_RST || TRANSMIT_DATA_IN) ? 8'h00 : lo_cnt_next;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Release of receive data not caused by the bus
  sequence s_rx_rise;
    $rose(RECEIVE_DATA_OUT) && !$past(BUS_RX);
  endsequence
  sequence s_rx_hold;
    RECEIVE_DATA_OUT [*8];
  endsequence
  AST_TX_TIMEOUT: assert property (lo_cnt_reg > DOM_CYC + 2 |-> !CAN_TX_DRIVE)
    else $error("transmitter still on after dominant time-out");
  AST_TX_RECESSIVE: assert property (CAN_TX_DRIVE |-> !$past(TRANSMIT_DATA_IN))
    else $error("dominant driven without low transmit input");
  AST_RST_PENDING: assert property ($fell(SYS_RST) |-> ##[0:3] !RECEIVE_DATA_OUT)
    else $error("power-on event not signalled");
  AST_CLR_HOLD: assert property (s_rx_rise |-> s_rx_hold)
    else $error("receive data released too briefly");
  AST_CLR_CAUSE: assert property (s_rx_rise |-> $past(SCSN_N))
    else $error("receive data released without a clear");
  AST_WAKE_SUPPLY: assert property (!SUPPLY_ENABLE_OUT && PN_FRAME_ERR
    |-> ##[1:3] SUPPLY_ENABLE_OUT)
    else $error("supply not enabled on wake event");
  AST_SLEEP_CMD: assert property ($fell(SUPPLY_ENABLE_OUT)
    |-> $past(SCSN_N) && $past(SCSN_N, 2))
    else $error("sleep entered without a command");
  AST_SLEEP_TX: assert property (!SUPPLY_ENABLE_OUT |-> !CAN_TX_DRIVE)
    else $error("transmitter on in sleep");
endmodule
bind wef_core wef_props #(.TDOM_NS(TDOM_NS)) u_props (.CLK(CLK), .SYS_RST(SYS_RST),
  .SCSN_N(SCSN_N), .TRANSMIT_DATA_IN(TRANSMIT_DATA_IN), .BUS_RX(BUS_RX),
  .PN_FRAME_ERR(PN_FRAME_ERR), .RECEIVE_DATA_OUT(RECEIVE_DATA_OUT),
  .CAN_TX_DRIVE(CAN_TX_DRIVE), .SUPPLY_ENABLE_OUT(SUPPLY_ENABLE_OUT));
